// ==== shared/dochm_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the DO channel block
// Assumes: 20 MHz mclk, 32-bit APB data, one word per register
// Notes:   Included by bare name; definitions only
`ifndef DOCHM_DEFS_SVH
`define DOCHM_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DOCHM_CLK_PERIOD_NS 50
`define DOCHM_TICK_NS 100000
`define DOCHM_TICK_CYC (`DOCHM_TICK_NS / `DOCHM_CLK_PERIOD_NS)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DOCHM_OFF_CTRL 12'h000
`define DOCHM_OFF_LOW_WIDTH 12'h004
`define DOCHM_OFF_HIGH_WIDTH 12'h008
`define DOCHM_OFF_PULSE_TOTAL 12'h00c
`define DOCHM_OFF_DELAY 12'h010
`define DOCHM_OFF_CMD 12'h014
`define DOCHM_OFF_STATUS 12'h018

// ----------------------------------------
// Control fields
// ----------------------------------------
`define DOCHM_CTRL_MODE_LSB 0
`define DOCHM_CTRL_MODE_MSB 2
`define DOCHM_CTRL_LEVEL_BIT 3
`define DOCHM_CTRL_FSV_BIT 4
`define DOCHM_CTRL_FSV_EN_BIT 5
`define DOCHM_CTRL_TRIG_LSB 6
`define DOCHM_CTRL_TRIG_MSB 7
`define DOCHM_CTRL_FIXED_BIT 8
`define DOCHM_CTRL_ACH_LSB 9
`define DOCHM_CTRL_ACH_MSB 11
`define DOCHM_CTRL_MASK 32'h00000fff

// ----------------------------------------
// Command and status fields
// ----------------------------------------
`define DOCHM_CMD_START_BIT 0
`define DOCHM_CMD_STOP_BIT 1
`define DOCHM_STAT_OUT_BIT 0
`define DOCHM_STAT_RUN_BIT 1
`define DOCHM_STAT_SAFE_BIT 2
`define DOCHM_STAT_REM_LSB 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DOCHM_RST_CTRL 12'h000
`define DOCHM_RST_WIDTH 16'h0001
`define DOCHM_RST_TOTAL 16'h0001
`define DOCHM_RST_DELAY 16'h0001

`endif

// ==== shared/dochm_pkg.sv ====
// Purpose: Types shared by the DO channel block
// Assumes: Mode codes as written in the control register
// Notes:   Numbers that are not types live in dochm_defs.svh
package dochm_pkg;

  typedef enum logic [2:0]
  {
    DOCHM_MODE_DO = 3'h0,
    DOCHM_MODE_PULSE = 3'h1,
    DOCHM_MODE_RISE_DLY = 3'h2,
    DOCHM_MODE_FALL_DLY = 3'h3,
    DOCHM_MODE_ALARM = 3'h4
  } dochm_mode_t;

  typedef enum logic [1:0]
  {
    DOCHM_TRIG_OFF = 2'h0,
    DOCHM_TRIG_HIGH = 2'h1,
    DOCHM_TRIG_LOW = 2'h2
  } dochm_trig_t;

  typedef enum logic [2:0]
  {
    DOCHM_PST_IDLE = 3'b001,
    DOCHM_PST_LOW = 3'b010,
    DOCHM_PST_HIGH = 3'b100
  } dochm_pst_t;

endpackage : dochm_pkg

// ==== logic/dochm_sync.sv ====
// Purpose: Two-flop synchroniser for a bus of independent levels
// Assumes: Each bit is a slow level; no word coherency
// Notes:   First stage feeds only the second stage
module dochm_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] async_in, // Level from outside the domain
  output logic [W-1:0] sync_out // Synchronised level
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : dochm_sync

// ==== logic/dochm_tick.sv ====
// Purpose: Periodic one-cycle tick at the width and delay time base
// Assumes: Period count fits 16 bits
// Notes:   Tick is registered, so it is glitch free
`include "dochm_defs.svh"
module dochm_tick (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  output logic tick // One-cycle pulse every time-base period
);

  localparam logic [15:0] TICK_LAST = 16'(`DOCHM_TICK_CYC - 1);

  logic [15:0] cnt_ff;
  logic tick_ff;
  logic [15:0] nxt_cnt;
  logic nxt_tick;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb
  begin
    nxt_tick = (cnt_ff == TICK_LAST);
    nxt_cnt = nxt_tick ? 16'h0000 : cnt_ff + 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule : dochm_tick

// ==== logic/dochm_top.sv ====
// Purpose: One digital output channel with plain, pulse, delayed and alarm modes
// Assumes: APB slave, zero wait states; alarm and watchdog inputs are asynchronous levels
// Notes:   Fail-safe override acts on the pin only; the pulse engine keeps its state
//
// Design decisions made here: the register addresses and register access over APB.
`include "dochm_defs.svh"

// Notes on behaviour
// - Pulse mode gives train or finite burst
// - Separate low and high widths, tick units
// - Period and duty come only from widths
// - Fixed total stops after count; continuous repeats
// - Start command begins, stop command ends pulses
// - Rising-delay mode postpones low-to-high only
// - Falling-delay mode postpones high-to-low only
// - Alarm mode copies selected high/low alarm
// - Watchdog timeout forces fail-safe level
module dochm_top (
  input wire logic mclk, // System clock, 20 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready, always high
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error on unmapped address
  input wire logic [7:0] ai_high_alarm, // High alarm flags of analog inputs
  input wire logic [7:0] ai_low_alarm, // Low alarm flags of analog inputs
  input wire logic wdt_timeout, // Communication watchdog expired
  output logic dout // Digital output to the load
);

  logic tick;
  logic [7:0] hi_al;
  logic [7:0] lo_al;
  logic wdt_s;

  dochm_tick u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  dochm_sync #(.W(17)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({wdt_timeout, ai_low_alarm, ai_high_alarm}),
    .sync_out({wdt_s, lo_al, hi_al})
  );

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [11:0] ctrl_ff;
  logic [15:0] low_w_ff;
  logic [15:0] high_w_ff;
  logic [15:0] total_ff;
  logic [15:0] delay_ff;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic [11:0] nxt_ctrl;
  logic [15:0] nxt_low_w;
  logic [15:0] nxt_high_w;
  logic [15:0] nxt_total;
  logic [15:0] nxt_delay;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic wr_en;
  logic start_cmd;
  logic stop_cmd;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] status_w;

  logic [15:0] remain_ff;
  logic [15:0] ph_cnt_ff;
  dochm_pkg::dochm_pst_t pst_ff;
  logic dout_ff;

  dochm_pkg::dochm_mode_t mode;
  dochm_pkg::dochm_trig_t trig;
  logic fixed_total;
  logic cmd_level;

  assign mode = dochm_pkg::dochm_mode_t'(ctrl_ff[`DOCHM_CTRL_MODE_MSB:`DOCHM_CTRL_MODE_LSB]);
  assign trig = dochm_pkg::dochm_trig_t'(ctrl_ff[`DOCHM_CTRL_TRIG_MSB:`DOCHM_CTRL_TRIG_LSB]);
  assign fixed_total = ctrl_ff[`DOCHM_CTRL_FIXED_BIT];
  assign cmd_level = ctrl_ff[`DOCHM_CTRL_LEVEL_BIT];
  assign status_w = {remain_ff, 13'h0000, wdt_s & ctrl_ff[`DOCHM_CTRL_FSV_EN_BIT],
    pst_ff != dochm_pkg::DOCHM_PST_IDLE, dout_ff};

  // Strobes are honoured only as a whole low half-word; wider fields are narrow enough
  assign wr_en = psel & penable & pwrite & pstrb[0] & pstrb[1];
  assign start_cmd = wr_en & (paddr == `DOCHM_OFF_CMD) & pwdata[`DOCHM_CMD_START_BIT];
  assign stop_cmd = wr_en & (paddr == `DOCHM_OFF_CMD) & pwdata[`DOCHM_CMD_STOP_BIT];

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      `DOCHM_OFF_CTRL: rd_mux = {20'h00000, ctrl_ff};
      `DOCHM_OFF_LOW_WIDTH: rd_mux = {16'h0000, low_w_ff};
      `DOCHM_OFF_HIGH_WIDTH: rd_mux = {16'h0000, high_w_ff};
      `DOCHM_OFF_PULSE_TOTAL: rd_mux = {16'h0000, total_ff};
      `DOCHM_OFF_DELAY: rd_mux = {16'h0000, delay_ff};
      `DOCHM_OFF_CMD: rd_mux = 32'h00000000;
      `DOCHM_OFF_STATUS: rd_mux = status_w;
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_low_w = low_w_ff;
    nxt_high_w = high_w_ff;
    nxt_total = total_ff;
    nxt_delay = delay_ff;
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    // Answer is prepared in the setup cycle so data leaves a flop
    if (psel & ~penable)
    begin
      nxt_rdata = pwrite ? 32'h00000000 : rd_mux;
      nxt_err = ~mapped;
    end
    if (wr_en)
    begin
      unique case (paddr)
        `DOCHM_OFF_CTRL: nxt_ctrl = pwdata[11:0];
        `DOCHM_OFF_LOW_WIDTH: nxt_low_w = pwdata[15:0];
        `DOCHM_OFF_HIGH_WIDTH: nxt_high_w = pwdata[15:0];
        `DOCHM_OFF_PULSE_TOTAL: nxt_total = pwdata[15:0];
        `DOCHM_OFF_DELAY: nxt_delay = pwdata[15:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `DOCHM_RST_CTRL;
      low_w_ff <= `DOCHM_RST_WIDTH;
      high_w_ff <= `DOCHM_RST_WIDTH;
      total_ff <= `DOCHM_RST_TOTAL;
      delay_ff <= `DOCHM_RST_DELAY;
      rdata_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      low_w_ff <= nxt_low_w;
      high_w_ff <= nxt_high_w;
      total_ff <= nxt_total;
      delay_ff <= nxt_delay;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_ff;
  assign pslverr = err_ff & psel & penable;

  // ----------------------------------------
  // Pulse engine
  // ----------------------------------------
  dochm_pkg::dochm_pst_t nxt_pst;
  logic [15:0] nxt_ph_cnt;
  logic [15:0] nxt_remain;
  logic [15:0] low_last;
  logic [15:0] high_last;
  logic pulse_mode;

  // Zero width is taken as one tick so a phase never vanishes
  assign low_last = (low_w_ff == 16'h0000) ? 16'h0000 : low_w_ff - 16'h0001;
  assign high_last = (high_w_ff == 16'h0000) ? 16'h0000 : high_w_ff - 16'h0001;
  assign pulse_mode = (mode == dochm_pkg::DOCHM_MODE_PULSE);

  always_comb
  begin
    nxt_pst = pst_ff;
    nxt_ph_cnt = ph_cnt_ff;
    nxt_remain = remain_ff;
    unique case (pst_ff)
      dochm_pkg::DOCHM_PST_IDLE:
      begin
        if (start_cmd & pulse_mode & ~(fixed_total & (total_ff == 16'h0000)))
        begin
          nxt_pst = dochm_pkg::DOCHM_PST_LOW;
          nxt_ph_cnt = 16'h0000;
          nxt_remain = fixed_total ? total_ff : 16'h0000;
        end
      end
      dochm_pkg::DOCHM_PST_LOW:
      begin
        // period is low plus high width
        if (tick)
        begin
          if (ph_cnt_ff >= low_last)
          begin
            nxt_pst = dochm_pkg::DOCHM_PST_HIGH;
            nxt_ph_cnt = 16'h0000;
          end
          else
          begin
            nxt_ph_cnt = ph_cnt_ff + 16'h0001;
          end
        end
      end
      dochm_pkg::DOCHM_PST_HIGH:
      begin
        if (tick)
        begin
          if (ph_cnt_ff >= high_last)
          begin
            nxt_ph_cnt = 16'h0000;
            if (fixed_total & (remain_ff <= 16'h0001))
            begin
              nxt_pst = dochm_pkg::DOCHM_PST_IDLE;
              nxt_remain = 16'h0000;
            end
            else
            begin
              nxt_pst = dochm_pkg::DOCHM_PST_LOW;
              nxt_remain = fixed_total ? remain_ff - 16'h0001 : 16'h0000;
            end
          end
          else
          begin
            nxt_ph_cnt = ph_cnt_ff + 16'h0001;
          end
        end
      end
      default:
      begin
        nxt_pst = dochm_pkg::DOCHM_PST_IDLE;
      end
    endcase
    if (stop_cmd | ~pulse_mode)
    begin
      nxt_pst = dochm_pkg::DOCHM_PST_IDLE;
      nxt_ph_cnt = 16'h0000;
      nxt_remain = 16'h0000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pst_ff <= dochm_pkg::DOCHM_PST_IDLE;
      ph_cnt_ff <= 16'h0000;
      remain_ff <= 16'h0000;
    end
    else
    begin
      pst_ff <= nxt_pst;
      ph_cnt_ff <= nxt_ph_cnt;
      remain_ff <= nxt_remain;
    end
  end

  // ----------------------------------------
  // Delay engine and output select
  // ----------------------------------------
  logic [15:0] dly_cnt_ff;
  logic dly_out_ff;
  logic [15:0] nxt_dly_cnt;
  logic nxt_dly_out;
  logic nxt_dout;
  logic alarm_bit;
  logic [2:0] ach;

  assign ach = ctrl_ff[`DOCHM_CTRL_ACH_MSB:`DOCHM_CTRL_ACH_LSB];

  always_comb
  begin
    nxt_dly_cnt = 16'h0000;
    nxt_dly_out = cmd_level;
    if ((mode == dochm_pkg::DOCHM_MODE_RISE_DLY) & cmd_level & ~dly_out_ff)
    begin
      nxt_dly_out = 1'b0;
      nxt_dly_cnt = dly_cnt_ff;
      if (dly_cnt_ff >= delay_ff)
      begin
        nxt_dly_out = 1'b1;
        nxt_dly_cnt = 16'h0000;
      end
      else if (tick)
      begin
        nxt_dly_cnt = dly_cnt_ff + 16'h0001;
      end
    end
    else if ((mode == dochm_pkg::DOCHM_MODE_FALL_DLY) & ~cmd_level & dly_out_ff)
    begin
      nxt_dly_out = 1'b1;
      nxt_dly_cnt = dly_cnt_ff;
      if (dly_cnt_ff >= delay_ff)
      begin
        nxt_dly_out = 1'b0;
        nxt_dly_cnt = 16'h0000;
      end
      else if (tick)
      begin
        nxt_dly_cnt = dly_cnt_ff + 16'h0001;
      end
    end
  end

  always_comb
  begin
    unique case (trig)
      dochm_pkg::DOCHM_TRIG_HIGH: alarm_bit = hi_al[ach];
      dochm_pkg::DOCHM_TRIG_LOW: alarm_bit = lo_al[ach];
      default: alarm_bit = 1'b0;
    endcase
    unique case (mode)
      dochm_pkg::DOCHM_MODE_PULSE: nxt_dout = (pst_ff == dochm_pkg::DOCHM_PST_HIGH);
      dochm_pkg::DOCHM_MODE_RISE_DLY: nxt_dout = nxt_dly_out;
      dochm_pkg::DOCHM_MODE_FALL_DLY: nxt_dout = nxt_dly_out;
      dochm_pkg::DOCHM_MODE_ALARM: nxt_dout = alarm_bit;
      default: nxt_dout = cmd_level;
    endcase
    if (wdt_s & ctrl_ff[`DOCHM_CTRL_FSV_EN_BIT])
    begin
      nxt_dout = ctrl_ff[`DOCHM_CTRL_FSV_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dly_cnt_ff <= 16'h0000;
      dly_out_ff <= 1'b0;
      dout_ff <= 1'b0;
    end
    else
    begin
      dly_cnt_ff <= nxt_dly_cnt;
      dly_out_ff <= nxt_dly_out;
      dout_ff <= nxt_dout;
    end
  end

  assign dout = dout_ff;

endmodule : dochm_top

// ==== verif/dochm_top_asserts.sv ====
// Purpose: Port-level assertions for the DO channel block
// Assumes: Shadow copies of control, high width and delay follow APB writes
// Notes:   Bound to dochm_top below the module
`include "dochm_defs.svh"
module dochm_top_asserts (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic pready, // APB ready
  input wire logic [31:0] prdata, // APB read data
  input wire logic pslverr, // APB error
  input wire logic [7:0] ai_high_alarm, // High alarms
  input wire logic [7:0] ai_low_alarm, // Low alarms
  input wire logic wdt_timeout, // Watchdog expired
  input wire logic dout // Output pin
);
  localparam int TICK = `DOCHM_TICK_CYC;
  logic wr;
  logic [11:0] ctrl_ff, nxt_ctrl;
  logic [15:0] hi_ff, nxt_hi, dly_ff, nxt_dly;
  int age_ff, nxt_age, hrun_ff, nxt_hrun, wage_ff, nxt_wage, hw;
  logic fs_en, m_lo, m_hi, m4, asel;

  // ----
  // Shadow state
  // ----
  always_comb
  begin
    wr = psel && penable && pwrite && pstrb[0] && pstrb[1];
    nxt_ctrl = (wr && paddr == `DOCHM_OFF_CTRL) ? pwdata[11:0] : ctrl_ff;
    nxt_hi = (wr && paddr == `DOCHM_OFF_HIGH_WIDTH) ? pwdata[15:0] : hi_ff;
    nxt_dly = (wr && paddr == `DOCHM_OFF_DELAY) ? pwdata[15:0] : dly_ff;
    nxt_age = (nxt_ctrl[3] != ctrl_ff[3]) ? 0 : age_ff + 1;
    nxt_hrun = dout ? hrun_ff + 1 : 0;
    nxt_wage = wr ? 0 : wage_ff + 1;
    if (!rst_n)
    begin
      nxt_ctrl = 12'h000;
      nxt_hi = 16'h0001;
      nxt_dly = 16'h0001;
      nxt_wage = 0;
    end
  end

  always_ff @(posedge mclk)
  begin
    ctrl_ff <= nxt_ctrl;
    hi_ff <= nxt_hi;
    dly_ff <= nxt_dly;
    age_ff <= nxt_age;
    hrun_ff <= nxt_hrun;
    wage_ff <= nxt_wage;
  end

  assign fs_en = ctrl_ff[5];
  assign m_lo = (ctrl_ff[2:0] == 3'h0 || ctrl_ff[2:0] == 3'h2) && !ctrl_ff[3];
  assign m_hi = (ctrl_ff[2:0] == 3'h0 || ctrl_ff[2:0] == 3'h3) && ctrl_ff[3];
  assign m4 = ctrl_ff[2:0] == 3'h4;
  assign asel = (ctrl_ff[7:6] == 2'h1) ? ai_high_alarm[ctrl_ff[11:9]] :
                (ctrl_ff[7:6] == 2'h2 && ai_low_alarm[ctrl_ff[11:9]]);
  assign hw = (hi_ff == 16'h0) ? TICK : int'(hi_ff) * TICK;

  // ----
  // Properties
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Five samples cover two sync stages plus the output flop
  sequence s_calm(logic c);
    (c && !fs_en) [*5];
  endsequence

  property p_rdy;
    pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");

  property p_err_acc;
    pslverr |-> psel && penable;
  endproperty
  a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");

  property p_err_map;
    psel && penable && paddr > 12'h018 |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");

  property p_rd_ctrl;
    psel && penable && !pwrite && paddr == 12'h000 |-> prdata == {20'h0, ctrl_ff};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");

  property p_lo;
    s_calm(m_lo) |-> !dout;
  endproperty
  a_lo: assert property (p_lo)
    else $error("output not low");

  property p_hi;
    s_calm(m_hi) |-> dout;
  endproperty
  a_hi: assert property (p_hi)
    else $error("output not high");

  property p_alm_on;
    s_calm(m4 && asel) |-> dout;
  endproperty
  a_alm_on: assert property (p_alm_on)
    else $error("alarm not driven");

  property p_alm_off;
    s_calm(m4 && !asel) |-> !dout;
  endproperty
  a_alm_off: assert property (p_alm_off)
    else $error("alarm output stuck");

  property p_fs;
    (fs_en && wdt_timeout && $stable(ctrl_ff[4])) [*5] |-> dout == ctrl_ff[4];
  endproperty
  a_fs: assert property (p_fs)
    else $error("fail-safe level missing");

  property p_dly;
    !fs_en && dly_ff != 16'h0 && (ctrl_ff[2:0] == 3'h2 && $rose(dout) ||
      ctrl_ff[2:0] == 3'h3 && $fell(dout)) |-> age_ff + TICK >= int'(dly_ff) * TICK;
  endproperty
  a_dly: assert property (p_dly)
    else $error("delayed edge too early");

  property p_hiw;
    ctrl_ff[2:0] == 3'h1 && !fs_en && $fell(dout) && wage_ff > hrun_ff + 2 |-> hrun_ff == hw;
  endproperty
  a_hiw: assert property (p_hiw)
    else $error("high phase width wrong");
endmodule : dochm_top_asserts

bind dochm_top dochm_top_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .ai_high_alarm(ai_high_alarm),
  .ai_low_alarm(ai_low_alarm), .wdt_timeout(wdt_timeout), .dout(dout));

// ==== verif/dochm_load.sv ====
// Purpose: Load on the output pin that tallies pulses and widths
// Assumes: Widths are counted in clock cycles
// Notes:   Widths report the last completed phase only
module dochm_load (
  input wire logic mclk, // Clock
  input wire logic clr, // Clears the tallies
  input wire logic dout, // Pin under observation
  output int rises, // Rising edges seen
  output int hi_len, // Last high time
  output int lo_len // Last low time
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  int run = 0;

  always @(posedge mclk)
  begin
    last <= dout;
    run <= (dout === last) ? run + 1 : 1;
    if (clr)
    begin
      rises <= 0;
      hi_len <= 0;
      lo_len <= 0;
    end
    else if (dout === 1'b1 && last === 1'b0)
    begin
      rises <= rises + 1;
      lo_len <= run;
    end
    else if (dout === 1'b0 && last === 1'b1)
      hi_len <= run;
  end
endmodule : dochm_load

// ==== verif/tb_dochm_top.sv ====
// Purpose: Self-checking bench for the DO channel block
// Assumes: Zero-wait APB slave, 2000-cycle time base
// Notes:   Pulse widths come from the load model
`include "dochm_defs.svh"
module tb_dochm_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = `DOCHM_TICK_CYC;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] ai_high_alarm = 8'h00;
  logic [7:0] ai_low_alarm = 8'h00;
  logic wdt_timeout = 1'b0;
  logic clr = 1'b1;
  logic pready, pslverr, dout, rd_e;
  logic [31:0] prdata, rd_v;
  int rises, hi_len, lo_len, s, n;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  dochm_top u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ai_high_alarm(ai_high_alarm),
    .ai_low_alarm(ai_low_alarm), .wdt_timeout(wdt_timeout), .dout(dout));
  dochm_load u_load (.mclk(mclk), .clr(clr), .dout(dout), .rises(rises),
    .hi_len(hi_len), .lo_len(lo_len));

  initial forever #25 mclk = ~mclk;

  // Longest legal run is about 50000 cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, exp);
    chk({31'h0, rd_e}, 32'h0);
  endtask : rd

  task automatic stat(input logic [31:0] exp);
    xfer(1'b0, `DOCHM_OFF_STATUS, 32'h0);
    chk(rd_v & 32'h7, exp);
  endtask : stat

  task automatic settle(input logic v);
    repeat (5) @(posedge mclk);
    chk({31'h0, dout}, {31'h0, v});
  endtask : settle

  task automatic wt(input logic v, input int lim);
    int i = 0;
    while (dout !== v && i < lim)
    begin
      @(posedge mclk);
      i++;
    end
    chk({31'h0, dout}, {31'h0, v});
  endtask : wt

  task automatic wait_idle();
    do
    begin
      repeat (200) @(posedge mclk);
      xfer(1'b0, `DOCHM_OFF_STATUS, 32'h0);
    end
    while (rd_v[1] !== 1'b0);
    // Output flop trails the state by a cycle, so read the status once more
    xfer(1'b0, `DOCHM_OFF_STATUS, 32'h0);
  endtask : wait_idle

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // ----
  // Tests
  // ----
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    clr <= 1'b0;
    rd(`DOCHM_OFF_CTRL, 32'h0);
    for (int i = 1; i < 5; i++) rd(12'(4 * i), 32'h1);
    rd(`DOCHM_OFF_CMD, 32'h0);
    pstrb <= 4'h0;
    wr(`DOCHM_OFF_LOW_WIDTH, 32'h9);
    pstrb <= 4'hf;
    rd(`DOCHM_OFF_LOW_WIDTH, 32'h1);
    xfer(1'b0, 12'h01c, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    chk(rd_v, 32'h0);
    wr(`DOCHM_OFF_CMD, 32'h1);
    stat(32'h0);
    $display("test registers done");
    wr(`DOCHM_OFF_LOW_WIDTH, 32'h2);
    wr(`DOCHM_OFF_HIGH_WIDTH, 32'h1);
    wr(`DOCHM_OFF_PULSE_TOTAL, 32'h3);
    wr(`DOCHM_OFF_CTRL, 32'h101);
    clr <= 1'b1;
    wr(`DOCHM_OFF_CMD, 32'h1);
    clr <= 1'b0;
    stat(32'h2);
    chk(rd_v, 32'h00030002);
    wait_idle();
    chk(rd_v, 32'h0);
    chk(32'(rises), 32'h3);
    chk(32'(hi_len), 32'(TICK));
    chk(32'(lo_len), 32'(2 * TICK));
    $display("test fixed burst done");
    wr(`DOCHM_OFF_HIGH_WIDTH, 32'h0);
    wr(`DOCHM_OFF_LOW_WIDTH, 32'h1);
    wr(`DOCHM_OFF_CTRL, 32'h1);
    clr <= 1'b1;
    wr(`DOCHM_OFF_CMD, 32'h1);
    clr <= 1'b0;
    while (rises < 4) @(posedge mclk);
    chk(32'(hi_len), 32'(TICK));
    chk(32'(lo_len), 32'(TICK));
    wr(`DOCHM_OFF_CMD, 32'h3);
    stat(32'h0);
    n = rises;
    repeat (3 * TICK) @(posedge mclk);
    chk(32'(rises), 32'(n));
    $display("test continuous train done");
    wr(`DOCHM_OFF_DELAY, 32'h2);
    for (int m = 2; m < 4; m++)
    begin
      s = m - 2;
      wr(`DOCHM_OFF_CTRL, 32'(m + 8 * s));
      settle(s[0]);
      wr(`DOCHM_OFF_CTRL, 32'(m + 8 - 8 * s));
      repeat (TICK / 2) @(posedge mclk);
      chk({31'h0, dout}, 32'(s));
      wt(!s[0], 3 * TICK);
      wr(`DOCHM_OFF_CTRL, 32'(m + 8 * s));
      settle(s[0]);
    end
    $display("test delayed output done");
    ai_high_alarm <= 8'h20;
    ai_low_alarm <= 8'h10;
    for (int t = 0; t < 8; t++)
    begin
      wr(`DOCHM_OFF_CTRL, 32'(4 + (t % 4) * 64 + (4 + t / 4) * 512));
      settle(t == 5 || t == 2);
    end
    $display("test alarm output done");
    wr(`DOCHM_OFF_CTRL, 32'h30);
    wdt_timeout <= 1'b1;
    settle(1'b1);
    stat(32'h5);
    wr(`DOCHM_OFF_CTRL, 32'h28);
    settle(1'b0);
    wdt_timeout <= 1'b0;
    settle(1'b1);
    wr(`DOCHM_OFF_CTRL, 32'h10);
    wdt_timeout <= 1'b1;
    settle(1'b0);
    $display("test fail-safe done");
    wrap_up();
  end
endmodule : tb_dochm_top
